// >>> core/bsc_edge.sv
`timescale 1ns/1ps
// Flags a falling edge of a status level
module bsc_edge (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Level in, pulse out
	input  wire logic level_i,
	output logic      fall_o
);
	logic prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev <= 1'b0;
		end else begin
			prev <= level_i;
		end
	end

	assign fall_o = prev & ~level_i;
endmodule // bsc_edge

// >>> core/bsc_pkg.sv
// What this block does
// - Stride-select bit 9 set gives a 2048-byte line, clear gives 1024 bytes.
// - Depth-select bit 8 set gives 16-bit pixels, clear gives 8-bit pixels.
// - Status bit 2 is high while an operation is queued and not yet started.
// - A pipeline register write while an operation is queued overwrites its parameters.
// - Status bit 1 is high whenever the pipeline itself is processing data.
// - Status bit 0 is high during an operation until all its memory requests are handled.
package bsc_pkg;
	localparam logic [15:0] BSC_STATUS_ADDR = 16'h820c;
	localparam logic [15:0] BSC_IRQ_ST_ADDR = 16'h8220;
	localparam logic [15:0] BSC_IRQ_MK_ADDR = 16'h8224;
	localparam int          BSC_STRIDE_BIT  = 9;
	localparam int          BSC_DEPTH_BIT   = 8;
	localparam int          BSC_QUEUED_BIT  = 2;
	localparam int          BSC_PROC_BIT    = 1;
	localparam int          BSC_PROG_BIT    = 0;
	localparam logic [11:0] BSC_STRIDE_WIDE = 12'h800;
	localparam logic [11:0] BSC_STRIDE_NARR = 12'h400;
	localparam logic [4:0]  BSC_PIX_WIDE    = 5'h10;
	localparam logic [4:0]  BSC_PIX_NARR    = 5'h08;
	localparam logic [31:0] BSC_RESET_VAL   = 32'h0000_0000;
	localparam logic [2:0]  BSC_IRQ_NONE    = 3'h0;

	typedef struct packed {
		logic queued;
		logic processing;
		logic in_progress;
	} bsc_status_t;

	typedef struct packed {
		logic [11:0] stride_bytes;
		logic [4:0]  pixel_bits;
	} bsc_mode_t;
endpackage

// >>> core/bsc_top.sv
`timescale 1ns/1ps
module bsc_top
	import bsc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [15:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Pipeline condition inputs
	input  wire bsc_status_t pipe_status_i,
	// Pipeline mode outputs
	output bsc_mode_t        mode_o,
	output logic             stride_sel_o,
	output logic             depth_sel_o,
	// Interrupt
	output logic             irq_o
);
	////////////////////////////////////////////////////////////////////////////
	// Decode
	logic        stride_sel;
	logic        depth_sel;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;
	logic [2:0]  fall;
	bsc_status_t st;

	// Read words
	logic [31:0] ist_word;
	logic [31:0] imk_word;

	// Interrupt terms
	logic [2:0]  irq_set;
	logic        irq_clr;
	logic [2:0]  irq_kept;

	// Next register values
	logic        next_ack;
	logic [31:0] next_dat;
	logic        next_stride_sel;
	logic        next_depth_sel;
	logic [2:0]  next_irq_mask;
	logic        next_irq;

	wire req       = cyc_i & stb_i & ~ack_o;
	wire hit_stat  = adr_i == BSC_STATUS_ADDR;
	wire hit_ist   = adr_i == BSC_IRQ_ST_ADDR;
	wire hit_imk   = adr_i == BSC_IRQ_MK_ADDR;
	wire wr_stat   = req & we_i & hit_stat & sel_i[1];
	wire wr_mask   = req & we_i & hit_imk & sel_i[0];
	wire rd_ist    = req & ~we_i & hit_ist;

	assign st = pipe_status_i;

	wire [31:0] stat_word = {22'h0, stride_sel, depth_sel, 5'h0,
		st.queued, st.processing, st.in_progress};

	// Interrupt words, upper bits read zero
	assign ist_word = {29'h0, irq_status};
	assign imk_word = {29'h0, irq_mask};

	////////////////////////////////////////////////////////////////////////////
	// Read path
	// Unmapped addresses read zero
	wire [31:0] rd_mux = hit_stat ? stat_word :
		hit_ist ? ist_word :
		hit_imk ? imk_word : BSC_RESET_VAL;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt events: each condition ending
	wire [2:0] levels = {st.queued, st.processing, st.in_progress};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_edge
			bsc_edge u_edge (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.level_i (levels[g]),
				.fall_o  (fall[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Interrupt sticky bits
	// Sticky bit set and read clear terms
	assign irq_set  = fall;
	assign irq_clr  = rd_ist;
	assign irq_kept = irq_clr ? BSC_IRQ_NONE : irq_status;

	// Set wins over read clear
	wire [2:0] next_irq_status = irq_set | irq_kept;

	////////////////////////////////////////////////////////////////////////////
	// Mode translation
	// stride and depth translation
	bsc_mode_t next_mode;
	assign next_mode.stride_bytes = stride_sel ? BSC_STRIDE_WIDE : BSC_STRIDE_NARR;
	assign next_mode.pixel_bits   = depth_sel ? BSC_PIX_WIDE : BSC_PIX_NARR;

	////////////////////////////////////////////////////////////////////////////
	// Next register values
	// Bus answer one cycle after the request is taken
	assign next_ack = req;

	// Read data stands with ack only
	assign next_dat = (req & ~we_i) ? rd_mux : BSC_RESET_VAL;

	assign next_stride_sel = wr_stat ? dat_i[BSC_STRIDE_BIT] : stride_sel;
	assign next_depth_sel  = wr_stat ? dat_i[BSC_DEPTH_BIT] : depth_sel;

	// Mask write from the low byte lane
	assign next_irq_mask = wr_mask ? dat_i[2:0] : irq_mask;

	// Level interrupt from unmasked sticky bits
	assign next_irq = |(next_irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////
	// Bus answer
	// Acknowledge pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= next_ack;
		end
	end

	// Read data word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= BSC_RESET_VAL;
		end else begin
			dat_o <= next_dat;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration bits
	// stride reset to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stride_sel <= BSC_RESET_VAL[BSC_STRIDE_BIT];
		end else begin
			stride_sel <= next_stride_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			depth_sel <= BSC_RESET_VAL[BSC_DEPTH_BIT];
		end else begin
			depth_sel <= next_depth_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt registers
	// Sticky event bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= BSC_IRQ_NONE;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Mask bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= BSC_IRQ_NONE;
		end else begin
			irq_mask <= next_irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pipeline outputs
	// drive pipeline mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_o <= '0;
		end else begin
			mode_o <= next_mode;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stride_sel_o <= 1'b0;
		end else begin
			stride_sel_o <= stride_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			depth_sel_o <= 1'b0;
		end else begin
			depth_sel_o <= depth_sel;
		end
	end

	// Interrupt line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end
endmodule // bsc_top

// >>> verification/bsc_checker.sv
`timescale 1ns/1ps
module bsc_checker
	import bsc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
	input wire logic [15:0] adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	// Pipeline side
	input wire bsc_status_t pipe_status_i,
	input wire bsc_mode_t   mode_o,
	input wire logic        stride_sel_o, depth_sel_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_wide; stride_sel_o |-> mode_o.stride_bytes == BSC_STRIDE_WIDE; endproperty
	a_wide: assert property (p_wide) else $error("stride wrong");
	property p_pix; depth_sel_o |-> mode_o.pixel_bits == BSC_PIX_WIDE; endproperty
	a_pix: assert property (p_pix) else $error("depth wrong");
	property p_flags; cyc_i && stb_i && !ack_o && !we_i && adr_i == BSC_STATUS_ADDR
		|=> ack_o && dat_o[2:0] == $past(pipe_status_i); endproperty
	a_flags: assert property (p_flags) else $error("flags wrong");
	wire [1:0] cfg_wr_bits = {dat_i[BSC_STRIDE_BIT], dat_i[BSC_DEPTH_BIT]};
	property p_narrow; !$past(rst_i) && !stride_sel_o
		|-> mode_o.stride_bytes == BSC_STRIDE_NARR; endproperty
	a_narrow: assert property (p_narrow) else $error("narrow stride wrong");
	property p_pix_narrow; !$past(rst_i) && !depth_sel_o
		|-> mode_o.pixel_bits == BSC_PIX_NARR; endproperty
	a_pix_narrow: assert property (p_pix_narrow) else $error("narrow depth wrong");
	property p_cfg_write; cyc_i && stb_i && !ack_o && we_i && sel_i[1]
		&& adr_i == BSC_STATUS_ADDR |=> ##1 {stride_sel_o, depth_sel_o} == $past(cfg_wr_bits, 2);
		endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
endmodule // bsc_checker
bind bsc_top bsc_checker u_chk (.*);

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
	import bsc_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [15:0] adr_i = 0;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic        ack_o, stride_sel_o, depth_sel_o, irq_o;
	bsc_status_t pipe_status_i = '0;
	bsc_mode_t   mode_o;
	int          fails = 0, comparisons = 0, n = 0;
	bsc_top DUT (.*);
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n <= n + 1;
		if (n == 3000) begin
			fails++;
			stop_test;
		end
	end
	task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task stop_test;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_mode;
		wb(0, BSC_STATUS_ADDR, 0);
		chk("reset", BSC_RESET_VAL, rd);
		for (int i = 0; i < 4; i++) begin
			wb(1, BSC_STATUS_ADDR, {22'h0, i[1:0], 5'h0, 3'h7});
			wb(0, BSC_STATUS_ADDR, 0);
			chk("cfg", {22'h0, i[1:0], 8'h0}, rd);
			chk("line", i[1] ? BSC_STRIDE_WIDE : BSC_STRIDE_NARR, mode_o.stride_bytes);
			chk("pix", i[0] ? BSC_PIX_WIDE : BSC_PIX_NARR, mode_o.pixel_bits);
			chk("sel", i[1:0], {stride_sel_o, depth_sel_o});
		end
		$display("mode test done");
	endtask
	task t_status;
		for (int i = 0; i < 8; i++) begin
			pipe_status_i <= i[2:0];
			wb(0, BSC_STATUS_ADDR, 0);
			chk("flags", {22'h0, 2'h3, 5'h0, i[2:0]}, rd);
		end
		chk("masked", 0, irq_o);
		$display("status test done");
	endtask
	task t_irq;
		wb(0, BSC_IRQ_ST_ADDR, 0);
		chk("prior", 3, rd);
		wb(1, BSC_IRQ_MK_ADDR, 7);
		pipe_status_i <= 3'h0;
		wb(0, 16'h0100, 0);
		chk("unmapped", 0, rd);
		chk("irq", 1, irq_o);
		wb(0, BSC_IRQ_ST_ADDR, 0);
		chk("events", 7, rd);
		@(posedge clk_i);
		chk("cleared", 0, irq_o);
		$display("irq test done");
	endtask
	task poll(input int b, input logic [2:0] nxt);
		wb(0, BSC_STATUS_ADDR, 0);
		chk("busy", 1, rd[b]);
		pipe_status_i <= nxt;
		do wb(0, BSC_STATUS_ADDR, 0); while (rd[b] !== 1'b0);
		chk("left", nxt, rd[2:0]);
	endtask
	task t_poll;
		pipe_status_i <= 3'h7;
		poll(BSC_QUEUED_BIT, 3'h3);
		wb(1, BSC_STATUS_ADDR, {22'h0, 2'h2, 8'h0});
		poll(BSC_PROC_BIT, 3'h1);
		poll(BSC_PROG_BIT, 3'h0);
		chk("cfg", {22'h0, 2'h2, 8'h0}, rd);
		chk("line", BSC_STRIDE_WIDE, mode_o.stride_bytes);
		chk("pix", BSC_PIX_NARR, mode_o.pixel_bits);
		chk("pending", 1, irq_o);
		$display("poll test done");
	endtask
	task t_reset;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk("reset irq", 0, irq_o);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, BSC_STATUS_ADDR, 0);
		chk("reset cfg", BSC_RESET_VAL, rd);
		wb(0, BSC_IRQ_ST_ADDR, 0);
		chk("reset events", 0, rd);
		chk("reset line", BSC_STRIDE_NARR, mode_o.stride_bytes);
		$display("reset test done");
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_mode;
		t_status;
		t_irq;
		t_poll;
		t_reset;
		stop_test;
	end
endmodule // tb
